// [include/encp_pkg.sv]
// constants, types and reset values of the echo/noise parameter register bank
package encp_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [3:0] ENCP_REG_MODE      = 4'h0; // echo_mode_select in bit 0
	localparam logic [3:0] ENCP_REG_COMMIT    = 4'h1; // memory_commit_control
	localparam logic [3:0] ENCP_REG_ADDR_HIGH = 4'h6; // memory_address_high
	localparam logic [3:0] ENCP_REG_ADDR_LOW  = 4'h7; // memory_address_low
	localparam logic [3:0] ENCP_REG_DATA_HIGH = 4'h8; // memory_data_high
	localparam logic [3:0] ENCP_REG_DATA_LOW  = 4'h9; // memory_data_low
	localparam int         ENCP_ECHO_SEL_BIT  = 0;
	localparam int         ENCP_MEM_WR_BIT    = 7;    // memory_write_trigger
	localparam logic [7:0] ENCP_REG_RESET     = 8'h00;

	// ----------------------------------------
	// internal memory addresses
	// ----------------------------------------
	localparam logic [15:0] ENCP_MEM_SINGLE_AC = 16'h009b;
	localparam logic [15:0] ENCP_MEM_DUAL_AC   = 16'h0099;
	localparam logic [15:0] ENCP_MEM_DUAL_LINE = 16'h009a;
	localparam logic [15:0] ENCP_MEM_NC_PAR1   = 16'h01c8;
	localparam logic [15:0] ENCP_MEM_NC_PAR2   = 16'h01c2;

	// ----------------------------------------
	// default delay limits, in samples
	// ----------------------------------------
	localparam int ENCP_SAMPLES_PER_S   = 8000;
	localparam int ENCP_SINGLE_AC_MS    = 59;
	localparam int ENCP_DUAL_AC_MS      = 44;
	localparam int ENCP_DUAL_LINE_MS    = 15;
	localparam logic [15:0] ENCP_SINGLE_AC_DEF = 16'(ENCP_SINGLE_AC_MS * ENCP_SAMPLES_PER_S / 1000);
	localparam logic [15:0] ENCP_DUAL_AC_DEF   = 16'(ENCP_DUAL_AC_MS * ENCP_SAMPLES_PER_S / 1000);
	localparam logic [15:0] ENCP_DUAL_LINE_DEF = 16'(ENCP_DUAL_LINE_MS * ENCP_SAMPLES_PER_S / 1000);
	localparam logic [15:0] ENCP_NC_PAR_DEF    = 16'h0000; // plain default, not overridden

	// ----------------------------------------
	// noise level in tenths of dB, pad step in dB
	// ----------------------------------------
	localparam logic [7:0] ENCP_NL_17_0 = 8'haa;
	localparam logic [7:0] ENCP_NL_13_5 = 8'h87;
	localparam logic [7:0] ENCP_NL_8_0  = 8'h50;
	localparam logic [7:0] ENCP_NL_OFF  = 8'h00;
	localparam logic [4:0] ENCP_PAD_STEP_DB = 5'h06;

	// ----------------------------------------
	// pin synchroniser packing
	// ----------------------------------------
	localparam int ENCP_SYNC_W   = 19;
	localparam int ENCP_SY_ADDR  = 0;  // 4 bits
	localparam int ENCP_SY_DATA  = 4;  // 8 bits
	localparam int ENCP_SY_WRITE = 12;
	localparam int ENCP_SY_STRB  = 13;
	localparam int ENCP_SY_PDN   = 14;
	localparam int ENCP_SY_NOISE = 15; // 2 bits, hi at 16
	localparam int ENCP_SY_PAD   = 17; // 2 bits, hi at 18

	typedef struct packed {
		logic [ENCP_SYNC_W-1:0] s1;
		logic [ENCP_SYNC_W-1:0] s2;
	} encp_sync_s;

	typedef struct packed {
		logic             strobe_prev;
		logic [15:0][7:0] cr;
		logic             commit_pend;
		logic             normal;
		logic [15:0]      dly_single;
		logic [15:0]      dly_dual_ac;
		logic [15:0]      dly_dual_line;
		logic [15:0]      nc_par1;
		logic [15:0]      nc_par2;
		logic             nc_override;
		logic [7:0]       rdata;
		logic [15:0]      ac_dly;
		logic [15:0]      ln_dly;
		logic             line_en;
		logic [7:0]       noise_lvl;
		logic [4:0]       pad_db;
	} encp_state_s;

	localparam encp_state_s ENCP_STATE_RST = '{
		dly_single:    ENCP_SINGLE_AC_DEF,
		dly_dual_ac:   ENCP_DUAL_AC_DEF,
		dly_dual_line: ENCP_DUAL_LINE_DEF,
		nc_par1:       ENCP_NC_PAR_DEF,
		nc_par2:       ENCP_NC_PAR_DEF,
		ac_dly:        ENCP_DUAL_AC_DEF,
		ln_dly:        ENCP_DUAL_LINE_DEF,
		line_en:       1'b1,
		default:       '0
	};

endpackage

// [include/encp_sync_if.sv]
// carrier between the pin synchroniser and the register bank
interface encp_sync_if;
	import encp_pkg::*;
	logic [ENCP_SYNC_W-1:0] raw;  // pins as they arrive
	logic [ENCP_SYNC_W-1:0] sync; // pins after two flops
	modport bank (output raw, input sync);
	modport syncer (input raw, output sync);
endinterface

// [src/encp_sync.sv]
// two-flop synchroniser for all asynchronous host pins
module encp_sync import encp_pkg::*; (
	input  wire logic clk,
	input  wire logic rst,
	encp_sync_if.syncer pins
);

	encp_sync_s st_q;
	encp_sync_s st_d;

	// first stage feeds only the second stage
	always_comb begin
		st_d.s1 = pins.raw;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign pins.sync = st_q.s2;

endmodule

// [src/encp_regbank.sv]
// control register bank with staged internal parameter memory
module encp_regbank import encp_pkg::*; (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [3:0]  cr_addr,
	input  wire logic [7:0]  cr_wdata,
	input  wire logic        cr_write,
	input  wire logic        set_strobe,
	input  wire logic        powerdown_reset,
	input  wire logic        noise_level_sel_hi,
	input  wire logic        noise_level_sel_lo,
	input  wire logic        canceller_pad_sel_hi,
	input  wire logic        canceller_pad_sel_lo,
	output logic      [7:0]  cr_rdata,
	output logic             normal_mode,
	output logic             echo_mode_select,
	output logic             line_canceller_en,
	output logic      [15:0] acoustic_delay_limit,
	output logic      [15:0] line_delay_limit,
	output logic      [15:0] noise_param_1,
	output logic      [15:0] noise_param_2,
	output logic             noise_param_override,
	output logic      [7:0]  noise_level_tenth_db,
	output logic      [4:0]  canceller_input_gain,
	output logic      [4:0]  canceller_output_loss
);

	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------
	encp_sync_if sy ();

	// all pins packed into one synchroniser
	assign sy.raw = {canceller_pad_sel_hi, canceller_pad_sel_lo, noise_level_sel_hi, noise_level_sel_lo,
	                 powerdown_reset, set_strobe, cr_write, cr_wdata, cr_addr};

	encp_sync u_sync (
		.clk  (clk),
		.rst  (rst),
		.pins (sy.syncer)
	);

	logic [3:0]  s_addr;
	logic [7:0]  s_data;
	logic        s_write;
	logic        s_strobe;
	logic        s_pdn;
	logic [1:0]  s_noise;
	logic [1:0]  s_pad;
	logic        acc_edge;
	logic [15:0] mem_addr;
	logic [15:0] mem_data;

	assign s_addr   = sy.sync[ENCP_SY_ADDR +: 4];
	assign s_data   = sy.sync[ENCP_SY_DATA +: 8];
	assign s_write  = sy.sync[ENCP_SY_WRITE];
	assign s_strobe = sy.sync[ENCP_SY_STRB];
	assign s_pdn    = sy.sync[ENCP_SY_PDN];
	assign s_noise  = sy.sync[ENCP_SY_NOISE +: 2];
	assign s_pad    = sy.sync[ENCP_SY_PAD +: 2];

	// ----------------------------------------
	// state
	// ----------------------------------------
	encp_state_s st_q;
	encp_state_s st_d;

	assign acc_edge = s_strobe && !st_q.strobe_prev;
	assign mem_addr = {st_q.cr[ENCP_REG_ADDR_HIGH], st_q.cr[ENCP_REG_ADDR_LOW]};
	assign mem_data = {st_q.cr[ENCP_REG_DATA_HIGH], st_q.cr[ENCP_REG_DATA_LOW]};

	// next-state logic for the whole bank
	always_comb begin
		st_d = st_q;
		st_d.strobe_prev = s_strobe;
		st_d.commit_pend = 1'b0;
		if (s_pdn) begin
			// powerdown clears registers and returns to initial mode
			st_d = ENCP_STATE_RST;
			st_d.strobe_prev = s_strobe;
		end else begin
			// commit copies staged data and self-clears the bit in the same cycle
			if (st_q.commit_pend) begin
				st_d.cr[ENCP_REG_COMMIT][ENCP_MEM_WR_BIT] = 1'b0;
				case (mem_addr)
					ENCP_MEM_SINGLE_AC: st_d.dly_single = mem_data;
					ENCP_MEM_DUAL_AC:   st_d.dly_dual_ac = mem_data;
					ENCP_MEM_DUAL_LINE: st_d.dly_dual_line = mem_data;
					ENCP_MEM_NC_PAR1: begin
						st_d.nc_par1 = mem_data;
						st_d.nc_override = 1'b1;
					end
					ENCP_MEM_NC_PAR2: begin
						st_d.nc_par2 = mem_data;
						st_d.nc_override = 1'b1;
					end
					default: ;
				endcase
			end
			if (acc_edge) begin
				if (s_write) begin
					st_d.cr[s_addr] = s_data;
					if (s_addr == ENCP_REG_COMMIT && s_data[ENCP_MEM_WR_BIT]) begin
						st_d.commit_pend = 1'b1;
					end
					// register 0 write leaves initial mode
					if (s_addr == ENCP_REG_MODE) begin
						st_d.normal = 1'b1;
					end
				end else begin
					// present addressed register; staging registers are write-only
					case (s_addr)
						ENCP_REG_ADDR_HIGH, ENCP_REG_ADDR_LOW,
						ENCP_REG_DATA_HIGH, ENCP_REG_DATA_LOW: st_d.rdata = ENCP_REG_RESET;
						default:                               st_d.rdata = st_q.cr[s_addr];
					endcase
				end
			end
		end
		// active delay limits by echo mode
		if (st_q.cr[ENCP_REG_MODE][ENCP_ECHO_SEL_BIT]) begin
			st_d.ac_dly  = st_q.dly_single;
			st_d.ln_dly  = '0;
			st_d.line_en = 1'b0;
		end else begin
			st_d.ac_dly  = st_q.dly_dual_ac;
			st_d.ln_dly  = st_q.dly_dual_line;
			st_d.line_en = 1'b1;
		end
		case (s_noise)
			2'b00:   st_d.noise_lvl = ENCP_NL_17_0;
			2'b11:   st_d.noise_lvl = ENCP_NL_13_5;
			2'b10:   st_d.noise_lvl = ENCP_NL_8_0;
			default: st_d.noise_lvl = ENCP_NL_OFF;
		endcase
		// pad gain in 6 dB steps
		st_d.pad_db = 5'(s_pad * ENCP_PAD_STEP_DB);
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= ENCP_STATE_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// outputs, all from flops
	// ----------------------------------------
	assign cr_rdata              = st_q.rdata;
	assign normal_mode           = st_q.normal;
	assign echo_mode_select      = st_q.cr[ENCP_REG_MODE][ENCP_ECHO_SEL_BIT];
	assign line_canceller_en     = st_q.line_en;
	assign acoustic_delay_limit  = st_q.ac_dly;
	assign line_delay_limit      = st_q.ln_dly;
	assign noise_param_1         = st_q.nc_par1;
	assign noise_param_2         = st_q.nc_par2;
	assign noise_param_override  = st_q.nc_override;
	assign noise_level_tenth_db  = st_q.noise_lvl;
	assign canceller_input_gain  = st_q.pad_db;
	assign canceller_output_loss = st_q.pad_db;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_WRITE_STORES: assert property (@(posedge clk) disable iff (rst)
		(acc_edge && s_write && !s_pdn && s_addr != ENCP_REG_COMMIT) |=> st_q.cr[$past(s_addr)] == $past(s_data))
		else $error("write did not store data");

	AST_READ_SHOWS: assert property (@(posedge clk) disable iff (rst)
		(acc_edge && !s_write && !s_pdn && s_addr inside {[4'h0:4'h5], [4'ha:4'hf]})
		|=> cr_rdata == $past(st_q.cr[s_addr]))
		else $error("read did not present register");

	AST_HOLD: assert property (@(posedge clk) disable iff (rst)
		(!acc_edge && !s_pdn && !st_q.commit_pend) |=> $stable(st_q.cr))
		else $error("register changed without write or powerdown");

	AST_COMMIT_CLEAR: assert property (@(posedge clk) disable iff (rst)
		(acc_edge && s_write && !s_pdn && s_addr == ENCP_REG_COMMIT && s_data[ENCP_MEM_WR_BIT])
		|=> st_q.commit_pend ##1 !st_q.cr[ENCP_REG_COMMIT][ENCP_MEM_WR_BIT])
		else $error("commit bit did not self-clear");

	AST_SINGLE_MEM: assert property (@(posedge clk) disable iff (rst)
		(st_q.commit_pend && !s_pdn && mem_addr == ENCP_MEM_SINGLE_AC) |=> st_q.dly_single == $past(mem_data))
		else $error("single delay limit not committed");

	AST_NC_MEM: assert property (@(posedge clk) disable iff (rst)
		(st_q.commit_pend && !s_pdn && mem_addr == ENCP_MEM_NC_PAR1) |=> noise_param_1 == $past(mem_data))
		else $error("noise parameter not committed");

	AST_SINGLE_MODE: assert property (@(posedge clk) disable iff (rst)
		echo_mode_select |=> (!line_canceller_en && line_delay_limit == '0
		&& acoustic_delay_limit == $past(st_q.dly_single)))
		else $error("single mode outputs wrong");

	AST_DUAL_MODE: assert property (@(posedge clk) disable iff (rst)
		(s_pdn ##1 !echo_mode_select) |=> (line_canceller_en && acoustic_delay_limit == ENCP_DUAL_AC_DEF
		&& line_delay_limit == ENCP_DUAL_LINE_DEF))
		else $error("dual mode defaults wrong");

	AST_NORMAL: assert property (@(posedge clk) disable iff (rst)
		(acc_edge && s_write && !s_pdn && s_addr == ENCP_REG_MODE) |=> normal_mode)
		else $error("normal mode not entered");

	AST_PDN_INIT: assert property (@(posedge clk) disable iff (rst)
		s_pdn |=> !normal_mode && st_q.dly_single == ENCP_SINGLE_AC_DEF)
		else $error("powerdown did not restore initial mode");

	AST_ONE_ACCESS: assert property (@(posedge clk) disable iff (rst)
		(s_strobe && st_q.strobe_prev && !s_pdn && !st_q.commit_pend) |=> ($stable(st_q.cr) && $stable(cr_rdata)))
		else $error("held strobe gave another access");

	AST_NOISE: assert property (@(posedge clk) disable iff (rst)
		(s_noise == 2'b10) |=> noise_level_tenth_db == ENCP_NL_8_0)
		else $error("noise level decode wrong");

	AST_PAD: assert property (@(posedge clk) disable iff (rst)
		(s_pad == 2'b11) |=> (canceller_input_gain == 5'h12 && canceller_output_loss == 5'h12))
		else $error("pad gain decode wrong");

endmodule

// [verification/encp_host.sv]
// host model driving the control register and mode pins of the parameter bank
module encp_host (
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output logic      [3:0] addr,
	output logic      [7:0] wdata,
	output logic            wr,
	output logic            strobe,
	output logic            pdn,
	output logic            nc_hi,
	output logic            nc_lo,
	output logic            pad_hi,
	output logic            pad_lo
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle levels at time zero
	initial begin
		{addr, wdata, wr, strobe, pdn} = '0;
		{nc_hi, nc_lo, pad_hi, pad_lo} = '0;
	end

	// ----------------------------------------
	// register access
	// ----------------------------------------
	// held around strobe
	task automatic access(input logic [3:0] a, input logic [7:0] d, input logic w);
		@(posedge clk) #2;
		addr = a;
		wdata = d;
		wr = w;
		repeat (3) @(posedge clk);
		#2 strobe = 1'b1;
		repeat (6) @(posedge clk);
		#2 strobe = 1'b0;
		repeat (4) @(posedge clk);
		// data lines no longer held, show a fresh pattern
		#2 wdata = ~wdata;
	endtask

	// data moves while strobe is still held
	task automatic held(input logic [3:0] a, input logic [7:0] d1, input logic [7:0] d2);
		@(posedge clk) #2;
		addr = a;
		wdata = d1;
		wr = 1'b1;
		repeat (3) @(posedge clk);
		#2 strobe = 1'b1;
		repeat (5) @(posedge clk);
		#2 wdata = d2;
		repeat (5) @(posedge clk);
		#2 strobe = 1'b0;
		repeat (4) @(posedge clk);
	endtask

	// read result once settled
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		access(a, 8'h00, 1'b0);
		d = rdata;
	endtask

	task automatic commit(input logic [15:0] ma, input logic [15:0] md);
		access(4'h6, ma[15:8], 1'b1);
		access(4'h7, ma[7:0], 1'b1);
		access(4'h8, md[15:8], 1'b1);
		access(4'h9, md[7:0], 1'b1);
		access(4'h1, 8'h80, 1'b1);
	endtask

	task automatic powerdown();
		@(posedge clk) #2 pdn = 1'b1;
		repeat (5) @(posedge clk);
		#2 pdn = 1'b0;
		repeat (4) @(posedge clk);
	endtask

	task automatic pins(input logic [1:0] nc, input logic [1:0] pad);
		@(posedge clk) #2;
		{nc_hi, nc_lo} = nc;
		{pad_hi, pad_lo} = pad;
		repeat (5) @(posedge clk);
	endtask
endmodule

// [verification/echo_noise_param_register_access_tb_top.sv]
// self-checking bench of the parameter register bank
module echo_noise_param_register_access_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import encp_pkg::*;

	logic        clk, rst, wr, strobe, pdn, nc_hi, nc_lo, pad_hi, pad_lo;
	logic [3:0]  addr;
	logic [7:0]  wdata, rdata, nlvl, rv;
	logic        normal, echo_sel, line_en, ovr;
	logic [15:0] ac_dly, ln_dly, np1, np2;
	logic [4:0]  gin, gout;
	int          errors, total_checks;
	localparam logic [7:0] NL_EXP [4] = '{8'haa, 8'h00, 8'h50, 8'h87};

	// ----------------------------------------
	// design and host
	// ----------------------------------------
	encp_host host_u (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .strobe(strobe),
		.pdn(pdn), .nc_hi(nc_hi), .nc_lo(nc_lo), .pad_hi(pad_hi), .pad_lo(pad_lo));
	encp_regbank dut_u (.clk(clk), .rst(rst), .cr_addr(addr), .cr_wdata(wdata), .cr_write(wr),
		.set_strobe(strobe), .powerdown_reset(pdn), .noise_level_sel_hi(nc_hi),
		.noise_level_sel_lo(nc_lo), .canceller_pad_sel_hi(pad_hi), .canceller_pad_sel_lo(pad_lo),
		.cr_rdata(rdata), .normal_mode(normal), .echo_mode_select(echo_sel),
		.line_canceller_en(line_en), .acoustic_delay_limit(ac_dly), .line_delay_limit(ln_dly),
		.noise_param_1(np1), .noise_param_2(np2), .noise_param_override(ovr),
		.noise_level_tenth_db(nlvl), .canceller_input_gain(gin), .canceller_output_loss(gout));

	// ----------------------------------------
	// checking and ending
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk(16'(rdata), 16'h0000);
		chk(16'(normal), 16'h0000);
		chk(16'(line_en), 16'h0001);
		chk(ac_dly, 16'h0160);
		chk(ln_dly, 16'h0078);
		$display("test reset values finished");
	endtask

	task automatic t_rw();
		host_u.access(4'h2, 8'ha5, 1'b1);
		host_u.access(4'hf, 8'h5a, 1'b1);
		host_u.rd(4'hf, rv);
		chk(16'(rv), 16'h005a);
		host_u.rd(4'h2, rv);
		chk(16'(rv), 16'h00a5);
		host_u.held(4'h3, 8'h66, 8'h99);
		host_u.rd(4'h3, rv);
		chk(16'(rv), 16'h0066);
		host_u.access(4'h8, 8'h3c, 1'b1);
		host_u.rd(4'h8, rv);
		chk(16'(rv), 16'h0000);
		$display("test write and read finished");
	endtask

	task automatic t_mode();
		host_u.access(4'h0, 8'h01, 1'b1);
		chk(16'(normal), 16'h0001);
		chk(16'({echo_sel, line_en}), 16'h0002);
		chk(ac_dly, 16'h01d8);
		chk(ln_dly, 16'h0000);
		host_u.access(4'h0, 8'h00, 1'b1);
		chk(16'({echo_sel, line_en}), 16'h0001);
		chk(ac_dly, 16'h0160);
		$display("test echo mode finished");
	endtask

	task automatic t_delay();
		host_u.powerdown();
		host_u.commit(16'h009b, 16'h00f0);
		host_u.access(4'h0, 8'h01, 1'b1);
		chk(ac_dly, 16'h00f0);
		host_u.rd(4'h1, rv);
		chk(16'(rv), 16'h0000);
		host_u.powerdown();
		chk(ac_dly, 16'h0160);
		host_u.commit(16'h0099, 16'h0100);
		host_u.commit(16'h009a, 16'h0050);
		host_u.access(4'h0, 8'h00, 1'b1);
		chk(ac_dly, 16'h0100);
		chk(ln_dly, 16'h0050);
		$display("test delay limits finished");
	endtask

	task automatic t_noise();
		host_u.powerdown();
		host_u.pins(2'b00, 2'b00);
		host_u.commit(16'h01c8, 16'h2000);
		host_u.commit(16'h01c2, 16'h0005);
		chk(np1, 16'h2000);
		chk(np2, 16'h0005);
		chk(16'(ovr), 16'h0001);
		host_u.powerdown();
		chk(np1, 16'h0000);
		chk(16'({ovr, normal}), 16'h0000);
		$display("test noise parameters finished");
	endtask

	task automatic t_pins();
		for (int i = 0; i < 4; i++) begin
			host_u.pins(2'(i), 2'(3 - i));
			chk(16'(nlvl), 16'(NL_EXP[i]));
			chk(16'(gin), 16'((3 - i) * 6));
			chk(16'(gout), 16'((3 - i) * 6));
		end
		$display("test mode pins finished");
	endtask

	// ----------------------------------------
	// clock, reset, sequence, watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		errors = 0;
		total_checks = 0;
		rst = 1'b1;
		repeat (6) @(posedge clk);
		#2 rst = 1'b0;
		t_reset();
		t_rw();
		t_mode();
		t_delay();
		t_noise();
		t_pins();
		stop_test();
	end

	// cut a hang short, well past the expected run
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		stop_test();
	end
endmodule
